// ---- adec_regs.svh ----
`ifndef ADEC_REGS_SVH
`define ADEC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADEC_CFG_OFS 8'h00
`define ADEC_STAT_OFS 8'h04
`define ADEC_CFG_RESET 8'h00

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define ADEC_CFG_EXT 0
`define ADEC_CFG_WHI 1
`define ADEC_CFG_WLO 2
`define ADEC_CFG_SIZE 3
`define ADEC_CFG_BOARD_ENABLE_BIT 4
`define ADEC_CFG_BANK 5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ADEC_STAT_TERM_LSB 0
`define ADEC_STAT_TERM_MSB 4
`define ADEC_STAT_OUT_LSB 5
`define ADEC_STAT_OUT_MSB 7

// ----------------------------------------------------------------
// Synchroniser depth
// ----------------------------------------------------------------
`define ADEC_SYNC_STAGES 2

`endif

// ---- adec_pkg.sv ----
package adec_pkg;
	typedef logic [31:0] adec_word_t;
	typedef logic [7:0] adec_cfg_t;
	typedef logic [8:0] adec_addr_t;
endpackage

// ---- adec_sync.sv ----
`include "adec_regs.svh"

module adec_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// The first stage feeds only the second; nothing else may look at it.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule

// ---- adec_top.sv ----
// Notes on behaviour
// [RULE1] Extended small-range term: A23..A20 high, extended option set, size clear.
// [RULE2] Extended large-range term: A23..A20 high, extended option set, size set.
// [RULE3] Low-range term: A23..A20 all low, extended option clear.
// [RULE4] Small window: A19,A18 high, A17 low, size clear, A16/A15 equal selects.
// [RULE5] Large extended window: A19 high, A18/A17 per high select, A16 equals low.
// [RULE6] Drive card-selected, wide-data returns to host and board select to arbiter.
// [RULE7] Wide-data return low: enabled, bank clear, both qualifiers, any pairing matches.
// [RULE8] Card-selected return low: enabled, both qualifiers, any pairing; bank ignored.
// [RULE9] Board select low on any qualified match, or qualified setup cycle.
// [RULE10] Setup cycle is setup strobe low together with an IO cycle indication.
`include "adec_regs.svh"

module adec_top
	import adec_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Adapter bus pins
	input wire logic [8:0] bus_addr_hi,
	input wire logic addr24_valid,
	input wire logic refresh_n,
	input wire logic setup_n,
	input wire logic mem_io,
	// Decoder outputs
	output logic card_selected_return_n,
	output logic wide_data_return_n,
	output logic board_select_n
);
	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	// Decodes are sampled after two flops, so outputs trail the pins by three
	// clocks; the host must allow for that latency at this clock rate.
	logic [12:0] pins_s;
	adec_addr_t addr_s;
	logic addr24_s;
	logic refresh_n_s;
	logic setup_n_s;
	logic mem_io_s;

	adec_sync #(.WIDTH(13)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({bus_addr_hi, addr24_valid, refresh_n, setup_n, mem_io}),
		.sync_out(pins_s)
	);

	assign addr_s = pins_s[12:4];
	assign addr24_s = pins_s[3];
	assign refresh_n_s = pins_s[2];
	assign setup_n_s = pins_s[1];
	assign mem_io_s = pins_s[0];

	// ----------------------------------------------------------------
	// Option register and bus slave
	// ----------------------------------------------------------------
	adec_cfg_t cfg_r;
	logic ack_r;
	adec_word_t dat_r;
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	wire sel_cfg = (wb_adr_i == `ADEC_CFG_OFS);
	wire sel_stat = (wb_adr_i == `ADEC_STAT_OFS);
	wire cfg_wr = bus_req && wb_we_i && sel_cfg && wb_sel_i[0];
	wire extended_range_select = cfg_r[`ADEC_CFG_EXT];
	wire window_select_high = cfg_r[`ADEC_CFG_WHI];
	wire window_select_low = cfg_r[`ADEC_CFG_WLO];
	wire window_large = cfg_r[`ADEC_CFG_SIZE];
	wire board_enable_bit = cfg_r[`ADEC_CFG_BOARD_ENABLE_BIT];
	wire bank_bit = cfg_r[`ADEC_CFG_BANK];

	// ----------------------------------------------------------------
	// Address and cycle terms
	// ----------------------------------------------------------------
	wire top_high = &addr_s[8:5];
	wire top_low = ~|addr_s[8:5];
	wire ext_range_small_term = top_high && extended_range_select && !window_large; // RULE1
	wire ext_range_large_term = top_high && extended_range_select && window_large; // RULE2
	wire low_range_term = top_low && !extended_range_select; // RULE3
	wire small_window_term = addr_s[4] && addr_s[3] && !addr_s[2] && !window_large
		&& (addr_s[1] == window_select_high) && (addr_s[0] == window_select_low); // RULE4
	wire large_window_ext_term = addr_s[4]
		&& (addr_s[3] == window_select_high) && (addr_s[2] == !window_select_high)
		&& (addr_s[1] == window_select_low); // RULE5
	// Non-extended large window: only 0C0000 or 0D0000, chosen by the low select.
	wire large_window_low_term = addr_s[4] && addr_s[3] && !addr_s[2] && window_large
		&& (addr_s[1] == window_select_low);
	wire all_cycles = addr24_s && refresh_n_s;
	wire mem_cycle = setup_n_s && mem_io_s;
	wire setup_cycle = !setup_n_s && !mem_io_s; // RULE10
	wire any_match = (ext_range_small_term && small_window_term)
		|| (low_range_term && small_window_term)
		|| (ext_range_large_term && large_window_ext_term)
		|| (low_range_term && large_window_low_term);
	wire qual_match = any_match && all_cycles && mem_cycle;
	wire card_sel_nxt = !(board_enable_bit && qual_match); // RULE8
	wire wide_nxt = !(board_enable_bit && !bank_bit && qual_match); // RULE7
	wire board_sel_nxt = !(qual_match || (all_cycles && setup_cycle)); // RULE9

	wire [4:0] terms = {large_window_ext_term, small_window_term, low_range_term,
		ext_range_large_term, ext_range_small_term};
	adec_word_t stat_word;
	always_comb begin
		stat_word = '0;
		stat_word[`ADEC_STAT_TERM_MSB:`ADEC_STAT_TERM_LSB] = terms;
		stat_word[`ADEC_STAT_OUT_MSB:`ADEC_STAT_OUT_LSB] =
			{board_select_n, wide_data_return_n, card_selected_return_n};
	end
	wire [31:0] rd_nxt = sel_cfg ? {24'h000000, cfg_r} : (sel_stat ? stat_word : 32'h00000000);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `ADEC_CFG_RESET;
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= bus_req;
			dat_r <= bus_req ? rd_nxt : 32'h00000000;
			if (cfg_wr) begin
				cfg_r <= wb_dat_i[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	logic card_sel_r;
	logic wide_r;
	logic board_sel_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			card_sel_r <= 1'b1;
			wide_r <= 1'b1;
			board_sel_r <= 1'b1;
		end else begin
			card_sel_r <= card_sel_nxt; // RULE6
			wide_r <= wide_nxt; // RULE6
			board_sel_r <= board_sel_nxt; // RULE6
		end
	end

	assign card_selected_return_n = card_sel_r;
	assign wide_data_return_n = wide_r;
	assign board_select_n = board_sel_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	wire quals_on = board_enable_bit && all_cycles && mem_cycle;

	property p_ext_small;
		quals_on && top_high && extended_range_select && !window_large
			&& addr_s[4:2] == 3'h6 && addr_s[1:0] == {window_select_high, window_select_low}
			|=> !card_selected_return_n;
	endproperty
	a_ext_small: assert property (p_ext_small) else $error("extended small window missed"); // RULE1

	property p_ext_large;
		quals_on && top_high && extended_range_select && window_large && addr_s[4]
			&& addr_s[3:2] == {window_select_high, !window_select_high}
			&& addr_s[1] == window_select_low
			|=> !card_selected_return_n;
	endproperty
	a_ext_large: assert property (p_ext_large) else $error("extended large window missed"); // RULE2

	property p_low_range;
		quals_on && !top_low && !extended_range_select |=> card_selected_return_n;
	endproperty
	a_low_range: assert property (p_low_range) else $error("low range decoded off range"); // RULE3

	property p_small_win;
		quals_on && !window_large && !extended_range_select
			&& addr_s[1:0] != {window_select_high, window_select_low}
			|=> card_selected_return_n;
	endproperty
	a_small_win: assert property (p_small_win) else $error("small window select ignored"); // RULE4

	property p_large_win;
		quals_on && window_large && extended_range_select && addr_s[1] != window_select_low
			|=> card_selected_return_n;
	endproperty
	a_large_win: assert property (p_large_win) else $error("large window select ignored"); // RULE5

	property p_idle;
		!any_match && !setup_cycle
			|=> board_select_n && card_selected_return_n && wide_data_return_n;
	endproperty
	a_idle: assert property (p_idle) else $error("output active without a match"); // RULE6

	property p_bank;
		bank_bit |=> wide_data_return_n;
	endproperty
	a_bank: assert property (p_bank) else $error("wide data driven with bank set"); // RULE7

	property p_wide_follows;
		!bank_bit && board_enable_bit |=> wide_data_return_n == card_selected_return_n;
	endproperty
	a_wide_follows: assert property (p_wide_follows) else $error("wide data differs"); // RULE7

	property p_enable;
		!board_enable_bit |=> card_selected_return_n && wide_data_return_n;
	endproperty
	a_enable: assert property (p_enable) else $error("card select while disabled"); // RULE8

	property p_board_sel;
		qual_match |=> !board_select_n && (card_selected_return_n == !$past(board_enable_bit));
	endproperty
	a_board_sel: assert property (p_board_sel) else $error("board select missed match"); // RULE9

	property p_setup;
		all_cycles && !setup_n_s && !mem_io_s |=> !board_select_n;
	endproperty
	a_setup: assert property (p_setup) else $error("setup cycle not selected"); // RULE10
endmodule

// ---- adec_host_model.sv ----
module adec_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Requested cycle: 0 idle, 1 memory, 2 setup, 3 refresh
	input wire logic [8:0] req_addr,
	input wire logic [1:0] req_kind,
	// Adapter bus pins
	output logic [8:0] bus_addr_hi,
	output logic addr24_valid,
	output logic refresh_n,
	output logic setup_n,
	output logic mem_io
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] idle_r;
	logic idle;
	// ----------------------------------------------------------------
	// Idle bus
	// ----------------------------------------------------------------
	// Between cycles the lines show the inverse of the last address, so a stale
	// address never looks valid.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			idle_r <= 9'h155;
		else
			idle_r <= ~req_addr;
	end
	assign idle = (req_kind == 2'h0);
	assign bus_addr_hi = idle ? idle_r : req_addr;
	assign addr24_valid = !idle;
	assign refresh_n = (req_kind != 2'h3);
	assign setup_n = (req_kind != 2'h2);
	assign mem_io = idle ? idle_r[0] : (req_kind != 2'h2);
endmodule

// ---- adec_top_tb.sv ----
module adec_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wd = 32'h0, rd, dat_o;
	logic [8:0] h_addr = 9'h000, pa;
	logic [1:0] h_kind = 2'h0;
	logic ack, a24, rf_n, su_n, mio, card_n, wide_n, bsel_n;
	int err_count = 0, n_tests = 0;
	adec_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .req_addr(h_addr),
		.req_kind(h_kind), .bus_addr_hi(pa), .addr24_valid(a24), .refresh_n(rf_n),
		.setup_n(su_n), .mem_io(mio));
	adec_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .bus_addr_hi(pa), .addr24_valid(a24), .refresh_n(rf_n),
		.setup_n(su_n), .mem_io(mio), .card_selected_return_n(card_n),
		.wide_data_return_n(wide_n), .board_select_n(bsel_n));
	// ----------------------------------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge sys_clk);
		{cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		if (ack !== 1'b1) chk("ack", 1, 0);
		{cyc, stb, we} <= 3'b000;
	endtask
	// Expected status byte: {board, wide, card, five decode terms}.
	function automatic logic [7:0] exp_st(logic [8:0] a, logic [7:0] c, logic [1:0] k);
		logic t1, t2, t3, t4, t5, t6, m, al, mm;
		t1 = &a[8:5] & c[0] & !c[3];
		t2 = &a[8:5] & c[0] & c[3];
		t3 = ~|a[8:5] & !c[0];
		t4 = a[4] & a[3] & !a[2] & !c[3] & (a[1] == c[1]) & (a[0] == c[2]);
		t5 = a[4] & (c[1] ? a[3] & !a[2] : !a[3] & a[2]) & (a[1] == c[2]);
		t6 = a[4] & a[3] & !a[2] & c[3] & (a[1] == c[2]);
		m = t1 & t4 | t3 & t4 | t2 & t5 | t3 & t6;
		al = (k == 2'h1) | (k == 2'h2);
		mm = (k == 2'h1) & m;
		return {!(al & mm | al & (k == 2'h2)), !(c[4] & !c[5] & al & mm),
			!(c[4] & al & mm), t5, t4, t3, t2, t1};
	endfunction
	task automatic run(input logic [8:0] a, input logic [1:0] k, input logic [7:0] c);
		logic [7:0] e;
		// An idle host shows the inverse of the last address on the lines.
		e = exp_st(k == 2'h0 ? ~a : a, c, k);
		wb(1, 8'h00, {24'h0, c}, 4'h1);
		@(posedge sys_clk);
		{h_addr, h_kind} <= {a, k};
		repeat (5) @(negedge sys_clk);
		chk("outputs", e[7:5], {bsel_n, wide_n, card_n});
		wb(0, 8'h04, 32'h0, 4'hF);
		chk("status", e, rd);
		h_kind <= 2'h0;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("reset outputs", 3'h7, {bsel_n, wide_n, card_n});
		wb(0, 8'h00, 32'h0, 4'hF);
		chk("option reset", 0, rd);
	endtask
	task automatic t_small;
		for (int i = 0; i < 16; i++)
			run({{4{i[3]}}, 3'h6, i[1:0]}, 2'h1, {3'h0, 1'b1, 1'b0, i[0] ^ i[2], i[1], i[3]});
	endtask
	task automatic t_large;
		for (int i = 0; i < 4; i++) begin
			run({8'hFA + 8'(i), 1'b0}, 2'h1, {4'h1, 1'b1, i[0], i[1], 1'b1});
			run({8'h0C + 8'(i), 1'b1}, 2'h1, {4'h1, 1'b1, i[0], i[1], 1'b0});
		end
	endtask
	task automatic t_qual;
		run(9'h1F4, 2'h1, 8'h39);
		run(9'h1F4, 2'h1, 8'h09);
		run(9'h1F4, 2'h3, 8'h19);
		run(9'h1F4, 2'h0, 8'h19);
		run(9'h1F6, 2'h1, 8'h19);
		run(9'h19B, 2'h1, 8'h18);
	endtask
	task automatic t_setup;
		run(9'h0A5, 2'h2, 8'h00);
		run(9'h1EB, 2'h2, 8'h19);
	endtask
	task automatic t_regs;
		wb(1, 8'h00, 32'hFFFF_FFD5, 4'hF);
		wb(1, 8'h00, 32'h0000_0000, 4'hE);
		wb(1, 8'h08, 32'hFFFF_FFFF, 4'hF);
		wb(0, 8'h00, 32'h0, 4'hF);
		chk("option", 32'hD5, rd);
		wb(0, 8'h08, 32'h0, 4'hF);
		chk("unmapped", 0, rd);
	endtask
	task automatic final_report;
		$display("Tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		t_reset();
		t_small();
		t_large();
		t_qual();
		t_setup();
		t_regs();
		final_report();
	end
endmodule
